// ==== card_pkg.sv ====
// Purpose: Shared constants for the card deactivation and line direction logic
// Assumes: 200 MHz system clock
// Notes:   Times are given in their own unit, counts derived from them
package card_pkg;

	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned STAB_TIME_MS    = 10;
	localparam int unsigned STAB_CYCLES     = STAB_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned STEP_TIME_NS    = 1000;
	localparam int unsigned STEP_CYCLES     = (STEP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CLK_DIV_DEFAULT = 4;
	localparam logic        LINE_IDLE_RESET = 1'b1;
	localparam logic        CARD_LINE_RESET = 1'b0;

	typedef enum logic [1:0] {
		DIR_NEUTRAL,
		DIR_CARD_IN,
		DIR_HOST_IN
	} dir_t;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_ACTIVE,
		SEQ_RST_LOW,
		SEQ_CLK_LOW,
		SEQ_IO_LOW,
		SEQ_VCC_OFF
	} seq_t;

endpackage : card_pkg

// ==== line_arbiter.sv ====
// Purpose: Direction arbiter for one card/host line pair
// Assumes: Line inputs already synchronous; open-drain style pins
// Notes:   Enable low holds card side low, host side released high
`timescale 1ns/10ps
module line_arbiter
	import card_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic enable_i,
	input  wire logic card_in_i,
	input  wire logic host_in_i,
	output logic      card_out_o,
	output logic      card_oe_o,
	output logic      host_out_o,
	output logic      host_oe_o
);

	dir_t dir_reg, dir_next;
	logic card_prev_reg, card_prev_next;
	logic host_prev_reg, host_prev_next;
	logic card_drv_reg, card_drv_next;
	logic host_drv_reg, host_drv_next;

	always_comb begin
		dir_next       = dir_reg;
		card_prev_next = card_in_i;
		host_prev_next = host_in_i;
		card_drv_next  = 1'b1;
		host_drv_next  = 1'b1;
		if (!enable_i) begin
			dir_next      = DIR_NEUTRAL;
			card_drv_next = CARD_LINE_RESET; // see R8
		end else begin
			unique case (dir_reg)
				DIR_NEUTRAL: begin
					// Card wins a tie; a simultaneous fall cannot be ordered
					if (card_prev_reg && !card_in_i) begin
						dir_next      = DIR_CARD_IN; // see R10
						host_drv_next = 1'b0;
					end else if (host_prev_reg && !host_in_i) begin
						dir_next      = DIR_HOST_IN; // see R10
						card_drv_next = 1'b0;
					end
				end
				DIR_CARD_IN: begin
					host_drv_next = card_in_i; // see R10
					if (card_in_i)
						dir_next = DIR_NEUTRAL; // see R11
				end
				DIR_HOST_IN: begin
					card_drv_next = host_in_i; // see R10
					if (host_in_i)
						dir_next = DIR_NEUTRAL; // see R11
				end
				default: dir_next = DIR_NEUTRAL;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dir_reg       <= DIR_NEUTRAL;
			card_prev_reg <= 1'b1;
			host_prev_reg <= 1'b1;
			card_drv_reg  <= CARD_LINE_RESET; // see R8
			host_drv_reg  <= LINE_IDLE_RESET; // see R9
		end else begin
			dir_reg       <= dir_next;
			card_prev_reg <= card_prev_next;
			host_prev_reg <= host_prev_next;
			card_drv_reg  <= card_drv_next;
			host_drv_reg  <= host_drv_next;
		end
	end

	// Open drain: only low is driven, high comes from the pull-up
	assign card_out_o = 1'b0;
	assign card_oe_o  = !card_drv_reg;
	assign host_out_o = 1'b0;
	assign host_oe_o  = !host_drv_reg;

endmodule : line_arbiter

// ==== card_session_ctrl.sv ====
// Purpose: Session tracking, ordered deactivation, fault/presence flag, line arbitration
// Assumes: All inputs synchronous to clk_i; activation steps come from an outside sequencer
// Notes:   Card clock divided here with even ratio for a 50 percent duty cycle
//
// Summary of operation
// R1: Host raising session request ends the session and starts deactivation.
// R2: Over-current, overheat, supply faults or extraction start deactivation automatically.
// R3: Deactivation drops reset, then clock, then data line, then supply, each delayed.
// R4: Outside a session the flag shows card presence.
// R5: Outside a session faults neither change the flag nor start deactivation.
// R6: In a session, extraction or fault pulls the flag low.
// R7: Flag falls in the same cycle deactivation starts.
// R8: Card-side data and aux lines low after reset until reception enabled.
// R9: Host-side data and aux lines high after reset.
// R10: First line pair side to fall becomes input; other side copies it.
// R11: Rising edge on the input side returns both lines to neutral.
// R12: Divided card clock keeps duty cycle between 45 and 55 percent.
// R13: Session request acts on its falling edge, not its level.
// R14: Ignore activation for 10 ms after reset, supply recovery or power-down exit.
// R15: Session lasts from accepted request until deactivation completes.
`timescale 1ns/10ps
module card_session_ctrl
	import card_pkg::*;
#(
	parameter int unsigned STAB_COUNT = STAB_CYCLES,
	parameter int unsigned STEP_COUNT = STEP_CYCLES,
	parameter int unsigned LINES      = 3
)(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             session_request_n_i,
	input  wire logic             card_detect_input_i,
	input  wire logic             power_down_request_i,
	input  wire logic             vdd_fault_i,
	input  wire logic             vcc_fault_i,
	input  wire logic             over_current_i,
	input  wire logic             over_temp_i,
	input  wire logic             reception_enable_i,
	input  wire logic             host_card_reset_request_i,
	input  wire logic             clk_div_enable_i,
	input  wire logic [LINES-1:0] card_line_i,
	input  wire logic [LINES-1:0] host_line_i,
	output logic                  fault_presence_o,
	output logic                  fault_presence_oe_o,
	output logic                  session_active_o,
	output logic                  card_reset_o,
	output logic                  card_clock_o,
	output logic                  card_supply_en_o,
	output logic                  activate_start_o,
	output logic [LINES-1:0]      card_line_o,
	output logic [LINES-1:0]      card_line_oe_o,
	output logic [LINES-1:0]      host_line_o,
	output logic [LINES-1:0]      host_line_oe_o
);

	localparam int unsigned SW = $clog2(STAB_COUNT + 1);
	localparam int unsigned TW = $clog2(STEP_COUNT + 1);

	////////////////////////////////////////////////////////////////////////////////
	// Session and deactivation sequencer

	seq_t           seq_reg, seq_next;
	logic [SW-1:0]  stab_reg, stab_next;
	logic [TW-1:0]  step_reg, step_next;
	logic           req_prev_reg, req_prev_next;
	logic           rst_reg, rst_next;
	logic           clk_en_reg, clk_en_next;
	logic           io_en_reg, io_en_next;
	logic           vcc_reg, vcc_next;
	logic           flag_reg, flag_next;
	logic           start_reg, start_next;
	logic           fault;
	logic           req_fall;
	logic           step_done;

	assign fault     = over_current_i | over_temp_i | vdd_fault_i | vcc_fault_i
	                 | !card_detect_input_i;
	assign req_fall  = req_prev_reg && !session_request_n_i; // see R13
	assign step_done = (step_reg == TW'(STEP_COUNT));

	always_comb begin
		seq_next      = seq_reg;
		stab_next     = stab_reg;
		step_next     = '0;
		req_prev_next = session_request_n_i;
		rst_next      = rst_reg;
		clk_en_next   = clk_en_reg;
		io_en_next    = io_en_reg;
		vcc_next      = vcc_reg;
		flag_next     = card_detect_input_i; // see R4
		start_next    = 1'b0;
		// Supply loss or power-down restarts the settling wait
		if (vdd_fault_i || power_down_request_i)
			stab_next = '0; // see R14
		else if (stab_reg != SW'(STAB_COUNT))
			stab_next = stab_reg + SW'(1);
		if (seq_reg != SEQ_IDLE && seq_reg != SEQ_ACTIVE)
			step_next = step_done ? '0 : step_reg + TW'(1);
		unique case (seq_reg)
			SEQ_IDLE: begin
				// Faults ignored here; flag only tracks presence
				if (req_fall && stab_reg == SW'(STAB_COUNT) && card_detect_input_i
				    && !power_down_request_i) begin // see R5
					seq_next   = SEQ_ACTIVE; // see R15
					vcc_next   = 1'b1;
					start_next = 1'b1;
				end
			end
			SEQ_ACTIVE: begin
				rst_next    = host_card_reset_request_i;
				clk_en_next = reception_enable_i;
				io_en_next  = reception_enable_i;
				if (fault) begin
					flag_next = 1'b0; // see R6
					seq_next  = SEQ_RST_LOW; // see R2, R7
				end else if (session_request_n_i) begin
					seq_next  = SEQ_RST_LOW; // see R1
				end
			end
			SEQ_RST_LOW: begin
				flag_next = !fault && card_detect_input_i;
				if (step_done) begin
					rst_next = 1'b0; // see R3
					seq_next = SEQ_CLK_LOW;
				end
			end
			SEQ_CLK_LOW: begin
				flag_next = !fault && card_detect_input_i;
				if (step_done) begin
					clk_en_next = 1'b0; // see R3
					seq_next    = SEQ_IO_LOW;
				end
			end
			SEQ_IO_LOW: begin
				flag_next = !fault && card_detect_input_i;
				if (step_done) begin
					io_en_next = 1'b0; // see R3
					seq_next   = SEQ_VCC_OFF;
				end
			end
			SEQ_VCC_OFF: begin
				flag_next = !fault && card_detect_input_i;
				if (step_done) begin
					vcc_next = 1'b0; // see R3
					seq_next = SEQ_IDLE; // see R15
				end
			end
			default: seq_next = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			seq_reg      <= SEQ_IDLE;
			stab_reg     <= '0;
			step_reg     <= '0;
			req_prev_reg <= 1'b1;
			rst_reg      <= 1'b0;
			clk_en_reg   <= 1'b0;
			io_en_reg    <= 1'b0;
			vcc_reg      <= 1'b0;
			flag_reg     <= 1'b0;
			start_reg    <= 1'b0;
		end else begin
			seq_reg      <= seq_next;
			stab_reg     <= stab_next;
			step_reg     <= step_next;
			req_prev_reg <= req_prev_next;
			rst_reg      <= rst_next;
			clk_en_reg   <= clk_en_next;
			io_en_reg    <= io_en_next;
			vcc_reg      <= vcc_next;
			flag_reg     <= flag_next;
			start_reg    <= start_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Card clock: even divider toggles, so duty is exactly half

	localparam int unsigned HALF = CLK_DIV_DEFAULT / 2;
	localparam int unsigned DW   = $clog2(HALF + 1);

	logic [DW-1:0] div_reg, div_next;
	logic          cclk_reg, cclk_next;

	always_comb begin
		div_next  = div_reg;
		cclk_next = cclk_reg;
		if (!clk_en_reg) begin
			div_next  = '0;
			cclk_next = 1'b0; // see R3
		end else if (!clk_div_enable_i) begin
			cclk_next = !cclk_reg;
		end else if (div_reg == DW'(HALF - 1)) begin
			div_next  = '0;
			cclk_next = !cclk_reg; // see R12
		end else begin
			div_next = div_reg + DW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			div_reg  <= '0;
			cclk_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			cclk_reg <= cclk_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Line pairs

	for (genvar i = 0; i < LINES; i++) begin : g_line
		line_arbiter u_arb (
			.clk_i      (clk_i),
			.rstn_i     (rstn_i),
			.enable_i   (io_en_reg),
			.card_in_i  (card_line_i[i]),
			.host_in_i  (host_line_i[i]),
			.card_out_o (card_line_o[i]),
			.card_oe_o  (card_line_oe_o[i]),
			.host_out_o (host_line_o[i]),
			.host_oe_o  (host_line_oe_o[i])
		);
	end

	assign fault_presence_o    = 1'b0;
	assign fault_presence_oe_o = !flag_reg;
	assign session_active_o    = (seq_reg != SEQ_IDLE);
	assign card_reset_o        = rst_reg;
	assign card_clock_o        = cclk_reg;
	assign card_supply_en_o    = vcc_reg;
	assign activate_start_o    = start_reg;

endmodule : card_session_ctrl

// ==== card_far_model.sv ====
// Purpose: Host and card far side of the three line pairs
// Assumes: Open-drain pairs with pull-ups on both sides
// Notes:   The bench decides when each far party pulls low
`timescale 1ns/10ps
module card_far_model #(
	parameter int N = 3
)(
	input  wire logic [N-1:0] card_oe_i,
	input  wire logic [N-1:0] host_oe_i,
	input  wire logic [N-1:0] card_pull_i,
	input  wire logic [N-1:0] host_pull_i,
	output logic      [N-1:0] card_line_o,
	output logic      [N-1:0] host_line_o
);
	// Pull-up wins unless a party pulls, so a released line never keeps a stale low
	assign card_line_o = ~(card_oe_i | card_pull_i);
	assign host_line_o = ~(host_oe_i | host_pull_i);
endmodule : card_far_model

// ==== card_session_chk.sv ====
// Purpose: Port checker for card_session_ctrl
// Assumes: One clock, sync active-low reset
// Notes:   Loose step bounds; exact gaps are measured by the bench
`timescale 1ns/10ps
module card_session_chk #(
	parameter int unsigned STEP_COUNT = 3,
	parameter int unsigned LINES      = 3
)(
	input wire logic             clk_i,
	input wire logic             rstn_i,
	input wire logic             session_request_n_i,
	input wire logic             card_detect_input_i,
	input wire logic             power_down_request_i,
	input wire logic             vdd_fault_i,
	input wire logic             vcc_fault_i,
	input wire logic             over_current_i,
	input wire logic             over_temp_i,
	input wire logic             reception_enable_i,
	input wire logic [LINES-1:0] card_line_i,
	input wire logic             fault_presence_oe_o,
	input wire logic             session_active_o,
	input wire logic             card_reset_o,
	input wire logic             card_clock_o,
	input wire logic             card_supply_en_o,
	input wire logic             activate_start_o,
	input wire logic [LINES-1:0] card_line_oe_o,
	input wire logic [LINES-1:0] host_line_oe_o
);
	localparam int DMAX = 4 * STEP_COUNT + 12;
	logic flt;
	assign flt = vdd_fault_i | vcc_fault_i | over_current_i | over_temp_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////////////////////////////////////////////
	// First trigger cycle only, before the flag has fallen
	sequence s_fault;
		session_active_o && !fault_presence_oe_o && !session_request_n_i
			&& (flt || !card_detect_input_i);
	endsequence
	sequence s_host_end;
		session_active_o && !fault_presence_oe_o && $rose(session_request_n_i);
	endsequence
	sequence s_deact_run;
		card_supply_en_o [*3] ##1 (##[0:DMAX] !card_supply_en_o);
	endsequence
	property p_flag_idle;
		$past(rstn_i) && !session_active_o && !$past(session_active_o)
			|-> fault_presence_oe_o == !$past(card_detect_input_i);
	endproperty
	property p_idle_quiet;
		!session_active_o |-> !card_supply_en_o && !card_reset_o;
	endproperty
	property p_fault_flag;
		s_fault |=> fault_presence_oe_o;
	endproperty
	property p_fault_deact;
		s_fault |=> s_deact_run;
	endproperty
	property p_host_deact;
		s_host_end |=> s_deact_run;
	endproperty
	property p_order;
		$fell(card_supply_en_o) |-> !card_reset_o && !card_clock_o && (&card_line_oe_o);
	endproperty
	property p_start;
		activate_start_o |-> $past(session_request_n_i, 2) && !$past(session_request_n_i)
			&& $past(card_detect_input_i) && !$past(power_down_request_i);
	endproperty
	property p_lines_idle;
		!session_active_o |-> (&card_line_oe_o) && host_line_oe_o == '0;
	endproperty
	property p_claim;
		session_active_o && reception_enable_i && $fell(card_line_i[0])
			&& !card_line_oe_o[0] && !host_line_oe_o[0] |-> ##[1:4] host_line_oe_o[0];
	endproperty
	property p_release;
		host_line_oe_o[0] && $rose(card_line_i[0]) |-> ##[1:4] !host_line_oe_o[0];
	endproperty
	a_flag_idle: assert property (p_flag_idle) else $error("flag not presence");
	a_idle_quiet: assert property (p_idle_quiet) else $error("card live idle");
	a_fault_flag: assert property (p_fault_flag) else $error("flag not low");
	a_fault_deact: assert property (p_fault_deact) else $error("fault deact");
	a_host_deact: assert property (p_host_deact) else $error("host deact");
	a_order: assert property (p_order) else $error("supply off early");
	a_start: assert property (p_start) else $error("bad start");
	a_lines_idle: assert property (p_lines_idle) else $error("lines idle");
	a_claim: assert property (p_claim) else $error("no copy");
	a_release: assert property (p_release) else $error("no neutral");
endmodule : card_session_chk

bind card_session_ctrl card_session_chk #(.STEP_COUNT(STEP_COUNT), .LINES(LINES)) u_chk (.*);

// ==== tb_top.sv ====
// Purpose: Self-checking bench for card_session_ctrl
// Assumes: Short stabilisation and step counts
// Notes:   Fault kinds and line sides drawn from a fixed seed
`timescale 1ns/10ps
module tb_top;
	localparam int unsigned STAB = 50;
	localparam int unsigned STEP = 3;
	logic       clk       = 1'b0;
	logic       rstn      = 1'b0;
	logic       req_n     = 1'b1;
	logic       det       = 1'b0;
	logic       pd        = 1'b0;
	logic       rx_en     = 1'b0;
	logic       div_en    = 1'b0;
	logic [3:0] flt       = 4'h0;
	logic [2:0] card_pull = 3'h0;
	logic [2:0] host_pull = 3'h0;
	logic [2:0] card_line, host_line, card_oe, host_oe;
	logic       flag_oe, sess, c_rst, c_clk, c_sup;
	logic       fp_val;
	logic [2:0] cl_val, hl_val;
	int         n_errors  = 0;
	int         n_checks  = 0;
	always #2.5 clk = ~clk;
	card_session_ctrl #(.STAB_COUNT(STAB), .STEP_COUNT(STEP)) u_card_session_ctrl (
		.clk_i(clk), .rstn_i(rstn), .session_request_n_i(req_n), .card_detect_input_i(det),
		.power_down_request_i(pd), .vdd_fault_i(flt[0]), .vcc_fault_i(flt[1]),
		.over_current_i(flt[2]), .over_temp_i(flt[3]), .reception_enable_i(rx_en),
		.host_card_reset_request_i(1'b1), .clk_div_enable_i(div_en), .card_line_i(card_line),
		.host_line_i(host_line), .fault_presence_o(fp_val), .fault_presence_oe_o(flag_oe),
		.session_active_o(sess), .card_reset_o(c_rst), .card_clock_o(c_clk),
		.card_supply_en_o(c_sup), .activate_start_o(), .card_line_o(cl_val),
		.card_line_oe_o(card_oe), .host_line_o(hl_val), .host_line_oe_o(host_oe));
	card_far_model u_card_far_model (.card_oe_i(card_oe), .host_oe_i(host_oe),
		.card_pull_i(card_pull), .host_pull_i(host_pull), .card_line_o(card_line),
		.host_line_o(host_line));
	////////////////////////////////////////////////////////////////////////
	function automatic int gap(input int n);
		return n * (STEP + 1);
	endfunction : gap
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic wait_sess(input logic v);
		for (int i = 0; i < 200 && sess !== v; i++) @(posedge clk) #1;
		if (sess !== v) begin
			n_errors++;
			finish_test();
		end
	endtask : wait_sess
	task automatic deact(input int k);
		int t_rst = -1;
		int t_clk = -1;
		int t_io  = -1;
		int t_sup = -1;
		int   cnt   = 0;
		logic s;
		@(posedge clk) div_en <= 1'($urandom);
		@(posedge clk) req_n <= 1'b0;
		wait_sess(1'b1);
		@(posedge clk) rx_en <= 1'b1;
		// Eight samples of a half-duty clock; lines settle meanwhile, so no claim races enable
		repeat (8) begin
			@(posedge clk) #1;
			cnt += (c_clk === 1'b1) ? 1 : 0;
		end
		chk(8'(cnt), 8'h4);
		for (int i = 0; i < 3; i++) begin
			s = 1'($urandom);
			@(posedge clk) begin
				card_pull[i] <= s;
				host_pull[i] <= !s;
			end
			repeat (5) @(posedge clk);
			#1 chk(8'({card_oe[i], host_oe[i]}), s ? 8'h1 : 8'h2);
			@(posedge clk) begin
				card_pull[i] <= 1'b0;
				host_pull[i] <= 1'b0;
			end
			repeat (5) @(posedge clk);
			#1 chk(8'({card_oe[i], host_oe[i], card_line[i], host_line[i]}), 8'h3);
		end
		@(posedge clk) begin
			if (k < 4) flt[k] <= 1'b1;
			else if (k == 4) det <= 1'b0;
			else req_n <= 1'b1;
		end
		// Last cycle each control was still live gives the step spacing
		for (int t = 0; t < 200 && sess === 1'b1; t++) begin
			@(posedge clk) #1;
			if (t == 0 && k < 5) chk(8'(flag_oe), 8'h1);
			if (c_rst) t_rst = t;
			if (c_clk) t_clk = t;
			if (!card_oe[0]) t_io = t;
			if (c_sup) t_sup = t;
		end
		wait_sess(1'b0);
		// Arbiter registers its enable, so card lines drop one cycle after their step
		chk(8'(t_io - t_rst), 8'(gap(2) + 1));
		chk(8'(t_sup - t_io), 8'(gap(1) - 1));
		// Card clock flop sits behind its enable: one cycle of lag
		chk(8'(t_clk > t_rst && t_clk <= t_rst + gap(1) + 1), 8'h1);
		@(posedge clk) begin
			flt <= 4'h0;
			det <= 1'b1;
			req_n <= 1'b1;
			rx_en <= 1'b0;
		end
		repeat (3) @(posedge clk);
		#1 chk(8'({flag_oe, card_oe, host_oe}), 8'h38);
		repeat (STAB + 5) @(posedge clk);
		$display("test deactivation kind %0d done", k);
	endtask : deact
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(8182));
		repeat (12) @(posedge clk);
		#1 chk(8'({flag_oe, card_oe, host_oe}), 8'h78);
		chk(8'({fp_val, cl_val, hl_val}), 8'h0);
		@(posedge clk) begin
			rstn <= 1'b1;
			det <= 1'b1;
		end
		repeat (10) @(posedge clk);
		req_n <= 1'b0;
		repeat (STAB) @(posedge clk);
		flt <= 4'hf;
		repeat (3) @(posedge clk);
		#1 chk(8'({sess, flag_oe}), 8'h0);
		@(posedge clk) begin
			flt <= 4'h0;
			pd <= 1'b1;
			req_n <= 1'b1;
		end
		@(posedge clk) req_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(8'(sess), 8'h0);
		@(posedge clk) begin
			pd <= 1'b0;
			req_n <= 1'b1;
		end
		repeat (STAB + 5) @(posedge clk);
		$display("test refusal done");
		for (int k = 0; k < 6; k++) deact(k);
		repeat (4) deact(int'($urandom % 6));
		finish_test();
	end
endmodule : tb_top
